// ==== watchdog_powerdown_wakeup.sv ====
// Purpose: watchdog timer, halt control and wake-up sequencing
// Assumes: clk is the system clock; core pulses arrive on clk
// Notes:   oscillator, reset pin and port A pins are asynchronous
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "wdt_pd_map.svh"
module watchdog_powerdown_wakeup
   import wdt_pd_pkg::*;
#(
   parameter int PA_WIDTH  = 8,
   parameter int IRQ_WIDTH = 6
)(
   // Clock and power-up reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Asynchronous pins
   input  wire logic                 wdt_osc_pin,
   input  wire logic                 external_reset_pin_n,
   input  wire logic [PA_WIDTH-1:0]  pa_pins,
   // Core instruction strobes
   input  wire logic                 single_clear_instruction,
   input  wire logic                 paired_clear_first,
   input  wire logic                 paired_clear_second,
   input  wire logic                 halt_instruction,
   // Core interrupt state
   input  wire logic [IRQ_WIDTH-1:0] irq_request,
   input  wire logic [IRQ_WIDTH-1:0] irq_enable,
   input  wire logic                 stack_full,
   // Outputs to core and clocking
   output logic                      chip_reset,
   output logic                      warm_reset,
   output logic                      core_hold,
   output logic                      cpu_resume,
   output logic                      cpu_take_irq,
   output logic                      sys_osc_en,
   output logic                      wdt_osc_en
);
   localparam int SW = PA_WIDTH + 2;

   // Count at which the selected tap overflows
   function automatic logic [`WDT_CNT_W-1:0] tap_limit(input logic [1:0] sel);
      logic [`WDT_CNT_W:0] full;
      full = '0;
      full[`RATIO_BASE_EXP + sel] = 1'b1;
      tap_limit = full[`WDT_CNT_W-1:0] - 16'h0001;
   endfunction

   logic [31:0]              cfg;
   logic                     timeout_flag;
   logic                     powerdown_flag;
   pm_state_e                state;
   wake_cause_e              cause;
   logic [`WDT_CNT_W-1:0]    wdt_count;
   logic [SW-1:0]            sy1, sy2, sy3, in_stable, rise_q, fall_q;
   logic [1:0]               div;
   logic                     first_seen, second_seen;
   logic [IRQ_WIDTH-1:0]     irq_block;
   logic [10:0]              wake_cnt;
   logic                     take_pending;

   wire logic       cfg_en     = cfg[`CFG_EN_BIT];
   wire logic       cfg_src    = cfg[`CFG_SRC_BIT];
   wire logic [1:0] cfg_ratio  = cfg[`CFG_RATIO_LSB +: 2];
   wire logic       cfg_paired = cfg[`CFG_PAIRED_BIT];
   wire logic [PA_WIDTH-1:0] wake_en = cfg[`CFG_WAKE_LSB +: PA_WIDTH];

   // Three-stage pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1 <= '1;
         sy2 <= '1;
         sy3 <= '1;
      end else begin
         sy1 <= {wdt_osc_pin, external_reset_pin_n, pa_pins};
         sy2 <= sy1;
         sy3 <= sy2;
      end
   end

   // A change counts once stages two and three agree
   wire logic [SW-1:0] agree = ~(sy2 ^ sy3);
   wire logic [SW-1:0] chg   = agree & (sy3 ^ in_stable);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_stable <= '1;
         rise_q    <= '0;
         fall_q    <= '0;
      end else begin
         in_stable <= in_stable ^ chg;
         rise_q    <= chg & sy3;
         fall_q    <= chg & ~sy3;
      end
   end
   wire logic ext_rst_low = ~in_stable[PA_WIDTH];
   wire logic osc_rise    = rise_q[PA_WIDTH+1];
   wire logic [PA_WIDTH-1:0] port_fall = fall_q[PA_WIDTH-1:0];

   // Instruction clock is clk/4; it runs only in PM_RUN, stopping in halt and in the wake wait
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 2'h0;
      end else if (state == PM_RUN) begin
         div <= div + 2'h1;
      end
   end
   wire logic instr_tick = (state == PM_RUN) && (div == 2'(`INSTR_DIV - 1));
   // Oscillator ticks arrive already synchronised, so a clear never races a tick
   wire logic wdt_tick   = cfg_src ? osc_rise : instr_tick;
   wire logic in_run     = (state == PM_RUN);
   wire logic halt_go    = in_run && halt_instruction;
   // Paired clear needs both halves, in either order
   wire logic pair_done = (paired_clear_first  || first_seen) &&
                          (paired_clear_second || second_seen);
   wire logic clr_eff   = cfg_en && in_run &&
                          (cfg_paired ? pair_done : single_clear_instruction);
   wire logic overflow  = cfg_en && wdt_tick && (wdt_count == tap_limit(cfg_ratio));
   // Remember the half of a paired clear seen so far
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_seen  <= 1'b0;
         second_seen <= 1'b0;
      end else if (!cfg_en || !cfg_paired || pair_done) begin
         first_seen  <= 1'b0;
         second_seen <= 1'b0;
      end else if (in_run) begin
         first_seen  <= first_seen  | paired_clear_first;
         second_seen <= second_seen | paired_clear_second;
      end
   end

   // Watchdog counter, synchronous, one increment per selected tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_count <= '0;
      end else if (!cfg_en) begin
         wdt_count <= '0;
      end else if (ext_rst_low || clr_eff || halt_go || overflow) begin
         wdt_count <= '0;
      end else if (wdt_tick) begin
         wdt_count <= wdt_count + 16'h0001;
      end
   end
   // Cause flags; a timeout in the same cycle as a clear still sets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timeout_flag   <= 1'b0;
         powerdown_flag <= 1'b0;
      end else begin
         if (overflow) begin
            timeout_flag <= 1'b1;
         end else if (halt_go || clr_eff) begin
            timeout_flag <= 1'b0;
         end
         if (halt_go) begin
            powerdown_flag <= 1'b1;
         end else if (clr_eff) begin
            powerdown_flag <= 1'b0;
         end
      end
   end

   wire logic irq_wake  = |(irq_request & ~irq_block);
   wire logic port_wake = |(port_fall & wake_en);
   wire logic irq_take  = |(irq_request & ~irq_block & irq_enable) && !stack_full;

   // Power mode sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state        <= PM_RUN;
         cause        <= WAKE_PIN;
         irq_block    <= '0;
         wake_cnt     <= '0;
         take_pending <= 1'b0;
      end else begin
         case (state)
            PM_RUN: begin
               wake_cnt <= '0;
               if (halt_go) begin
                  state     <= PM_HALT;
                  irq_block <= irq_request;
               end
            end
            PM_HALT: begin
               wake_cnt <= '0;
               if (ext_rst_low) begin
                  state <= PM_WAKE;
                  cause <= WAKE_PIN;
               end else if (overflow) begin
                  state <= PM_WAKE;
                  cause <= WAKE_WDT;
               end else if (port_wake) begin
                  state <= PM_WAKE;
                  cause <= WAKE_PORT;
               end else if (irq_wake) begin
                  state        <= PM_WAKE;
                  cause        <= WAKE_IRQ;
                  take_pending <= irq_take;
               end
            end
            default: begin
               wake_cnt <= wake_cnt + 11'h001;
               if (wake_cnt == 11'(`WAKE_CYCLES - 1)) begin
                  state <= PM_RUN;
               end
            end
         endcase
      end
   end

   wire logic wake_done = (state == PM_WAKE) && (wake_cnt == 11'(`WAKE_CYCLES - 1));

   // Core-facing strobes; interrupt entry lags plain resume by one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chip_reset   <= 1'b0;
         warm_reset   <= 1'b0;
         cpu_resume   <= 1'b0;
         cpu_take_irq <= 1'b0;
         core_hold    <= 1'b0;
         sys_osc_en   <= 1'b1;
         wdt_osc_en   <= 1'b0;
      end else begin
         chip_reset   <= ext_rst_low || (overflow && in_run);
         warm_reset   <= overflow && (state == PM_HALT);
         cpu_resume   <= wake_done && !(cause == WAKE_IRQ && take_pending);
         cpu_take_irq <= (state == PM_RUN) && take_pending && (cause == WAKE_IRQ) &&
                         !cpu_take_irq && $past(wake_done);
         core_hold    <= (state != PM_RUN);
         sys_osc_en   <= (state != PM_HALT);
         wdt_osc_en   <= cfg_en && cfg_src;
      end
   end

   // AXI4-Lite write side: address and data taken in either order
   logic [7:0]  aw_q;
   logic [31:0] w_q;
   logic [3:0]  ws_q;
   logic        aw_have, w_have;
   wire logic   aw_hs = s_axi_awvalid && s_axi_awready;
   wire logic   w_hs  = s_axi_wvalid && s_axi_wready;
   wire logic   do_wr = aw_have && w_have && !s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_q          <= 8'h00;
         w_q           <= 32'h0000_0000;
         ws_q          <= 4'h0;
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         cfg           <= `CFG_RESET;
      end else begin
         if (aw_hs) begin
            aw_q          <= s_axi_awaddr;
            aw_have       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_hs) begin
            w_q          <= s_axi_wdata;
            ws_q         <= s_axi_wstrb;
            w_have       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            if (aw_q == `OFS_CONFIG) begin
               s_axi_bresp <= `RESP_OKAY;
               for (int b = 0; b < 4; b++) begin
                  if (ws_q[b]) begin
                     cfg[8*b +: 8] <= w_q[8*b +: 8];
                  end
               end
            end else if (aw_q == `OFS_STATUS || aw_q == `OFS_COUNT) begin
               s_axi_bresp <= `RESP_OKAY;
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read side: one outstanding read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         if (s_axi_araddr == `OFS_CONFIG) begin
            s_axi_rdata <= cfg;
         end else if (s_axi_araddr == `OFS_STATUS) begin
            s_axi_rdata[`STS_TO_BIT]         <= timeout_flag;
            s_axi_rdata[`STS_PD_BIT]         <= powerdown_flag;
            s_axi_rdata[`STS_STATE_LSB +: 2] <= state;
            s_axi_rdata[`STS_CAUSE_LSB +: 2] <= cause;
         end else if (s_axi_araddr == `OFS_COUNT) begin
            s_axi_rdata[`WDT_CNT_W-1:0] <= wdt_count;
         end else begin
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Helper: cycles spent in the wake wait, counted independently
   logic [11:0] wake_age;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_age <= '0;
      end else if (state == PM_WAKE) begin
         wake_age <= wake_age + 12'h001;
      end else begin
         wake_age <= '0;
      end
   end

   property p_full_reset;
      @(posedge clk) disable iff (!rst_n)
      (overflow && in_run) |=> (chip_reset && timeout_flag);
   endproperty
   a_full_reset: assert property (p_full_reset) else $error("overflow gave no full reset");
   property p_warm_reset;
      @(posedge clk) disable iff (!rst_n)
      (overflow && state == PM_HALT && !ext_rst_low) |=> (warm_reset && !chip_reset
                                          && timeout_flag && state == PM_WAKE);
   endproperty
   a_warm_reset: assert property (p_warm_reset) else $error("halt overflow not warm");
   property p_halt_flags;
      @(posedge clk) disable iff (!rst_n)
      (halt_go && !overflow) |=> (powerdown_flag && !timeout_flag && wdt_count == '0);
   endproperty
   a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
   property p_disabled;
      @(posedge clk) disable iff (!rst_n)
      (!cfg_en && !halt_go) |=> (wdt_count == '0 && !warm_reset && $stable(powerdown_flag));
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled watchdog acted");
   property p_stop_in_halt;
      @(posedge clk) disable iff (!rst_n)
      (state == PM_HALT && !cfg_src && !ext_rst_low) |=> $stable(wdt_count);
   endproperty
   a_stop_in_halt: assert property (p_stop_in_halt) else $error("count moved in halt");
   property p_clear;
      @(posedge clk) disable iff (!rst_n)
      (clr_eff && !halt_go) |=> (wdt_count == '0 && !powerdown_flag);
   endproperty
   a_clear: assert property (p_clear) else $error("clear not applied");
   property p_wake_delay;
      @(posedge clk) disable iff (!rst_n)
      $fell(state == PM_WAKE) |-> (wake_age == 12'(`WAKE_CYCLES));
   endproperty
   a_wake_delay: assert property (p_wake_delay) else $error("wake wait not 1024");
   property p_osc_off;
      @(posedge clk) disable iff (!rst_n)
      (state == PM_HALT) ##1 (state == PM_HALT) |-> (!sys_osc_en && core_hold);
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator ran in halt");
   property p_port_wake;
      @(posedge clk) disable iff (!rst_n)
      (state == PM_HALT && port_wake && !ext_rst_low && !overflow)
         |=> (state == PM_WAKE && cause == WAKE_PORT) ##1 (state == PM_WAKE)[*3];
   endproperty
   a_port_wake: assert property (p_port_wake) else $error("port wake missed");
endmodule

// ==== wdt_pd_map.svh ====
// Purpose: offsets, fields, reset values and counts of the watchdog block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   included by bare name
`ifndef WDT_PD_MAP_SVH
`define WDT_PD_MAP_SVH
`define OFS_CONFIG       8'h00
`define OFS_STATUS       8'h04
`define OFS_COUNT        8'h08
`define CFG_RESET        32'h0000_0003
`define CFG_EN_BIT       0
`define CFG_SRC_BIT      1
`define CFG_RATIO_LSB    2
`define CFG_PAIRED_BIT   4
`define CFG_WAKE_LSB     8
`define STS_TO_BIT       0
`define STS_PD_BIT       1
`define STS_STATE_LSB    2
`define STS_CAUSE_LSB    4
`define RATIO_BASE_EXP   13
`define WDT_CNT_W        16
`define WAKE_CYCLES      1024
`define INSTR_DIV        4
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ==== wdt_pd_pkg.sv ====
// Purpose: types shared by the watchdog and power-down block
// Assumes: nothing beyond the map header
// Notes:   state codes follow declaration order from 0
package wdt_pd_pkg;
   typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_WAKE} pm_state_e;
   typedef enum logic [1:0] {WAKE_PIN, WAKE_PORT, WAKE_IRQ, WAKE_WDT} wake_cause_e;
endpackage

// ==== core_model.sv ====
// Purpose: behavioural processor core issuing watchdog and halt instructions
// Assumes: each strobe is one clk cycle, raised just after a rising edge
// Notes:   counts reset pulses so the bench can spot unexpected ones
`timescale 1ns/10ps
module core_model (
   // Clock
   input  wire logic clk,
   // Instruction strobes
   output logic      clr_single,
   output logic      clr_first,
   output logic      clr_second,
   output logic      halt,
   // Reset requests back from the watchdog
   input  wire logic chip_reset,
   input  wire logic warm_reset
);
   int chip_cnt = 0;
   int warm_cnt = 0;

   // Idle core issues nothing
   initial begin
      {halt, clr_second, clr_first, clr_single} = 4'h0;
   end

   // One instruction {halt, second, first, single}; a spare edge follows so calls never collide
   task automatic issue(input logic [3:0] m);
      {halt, clr_second, clr_first, clr_single} <= m;
      @(posedge clk);
      {halt, clr_second, clr_first, clr_single} <= 4'h0;
      @(posedge clk);
   endtask

   // Paired clear; a slow core may leave a gap between the halves
   task automatic clear_pair(input int gap);
      issue(4'h2);
      repeat (gap) @(posedge clk);
      issue(4'h4);
   endtask

   // Tally resets seen by the core
   always @(posedge clk) begin
      if (chip_reset) chip_cnt++;
      if (warm_reset) warm_cnt++;
   end
endmodule

// ==== watchdog_powerdown_wakeup_tb_top.sv ====
// Purpose: self-checking bench for the watchdog and power-down block
// Assumes: oscillator pin runs free at 25 MHz, four system clocks a period
// Notes:   both overflow scenarios use the 2^13 ratio to keep the run short
`timescale 1ns/10ps
`include "wdt_pd_map.svh"
`define CHK(g, e) check_eq(64'(g), 64'(e))
module watchdog_powerdown_wakeup_tb_top;
   logic        clk, rst_n, osc, pin_n, stack_full, aw_done, w_done;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        chip_rst, warm_rst, hold, resume, take_irq, sys_en, osc_en;
   logic        sc, pf, ps, hl;
   logic [7:0]  awaddr, araddr, pa;
   logic [31:0] wdata, rdata, d, d2;
   logic [1:0]  bresp, rresp, resp;
   logic [5:0]  irq_req, irq_en;
   logic [3:0]  hit, wstrb;
   int          mismatches = 0;
   int          comparisons = 0;
   int          n, k;

   watchdog_powerdown_wakeup dut_u (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wdt_osc_pin(osc), .external_reset_pin_n(pin_n), .pa_pins(pa),
      .single_clear_instruction(sc), .paired_clear_first(pf), .paired_clear_second(ps),
      .halt_instruction(hl), .irq_request(irq_req), .irq_enable(irq_en),
      .stack_full(stack_full), .chip_reset(chip_rst), .warm_reset(warm_rst),
      .core_hold(hold), .cpu_resume(resume), .cpu_take_irq(take_irq),
      .sys_osc_en(sys_en), .wdt_osc_en(osc_en)
   );

   core_model core_u (
      .clk(clk), .clr_single(sc), .clr_first(pf), .clr_second(ps), .halt(hl),
      .chip_reset(chip_rst), .warm_reset(warm_rst)
   );

   // System clock and the free-running watchdog oscillator, unrelated in phase
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      #3;
      forever #20 osc = ~osc;
   end

   task automatic check_eq(input logic [63:0] g, input logic [63:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask

   // AXI4-Lite write; spare edge at the end keeps bready from toggling twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // Wait for {warm, chip, take_irq, resume} under mask; the cycle limit stops a hang
   task automatic wait_ev(input logic [3:0] m, output int cyc, output logic [3:0] h);
      cyc = 0;
      h = 4'h0;
      while (h == 4'h0 && cyc < 40000) begin
         @(posedge clk);
         cyc++;
         h = m & {warm_rst, chip_rst, take_irq, resume};
      end
   endtask

   // Falling edge on port A bit 0, then the fixed wake wait before resuming
   task automatic port_wake();
      pa[0] <= 1'b0;
      wait_ev(4'h1, n, hit);
      pa[0] <= 1'b1;
      `CHK(n >= `WAKE_CYCLES && n <= `WAKE_CYCLES + 16, 1'b1);
   endtask

   task automatic print_verdict();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = '0;
      {pin_n, stack_full, pa} = {1'b1, 1'b0, 8'hFF};
      {irq_req, irq_en} = '0;
      wstrb = 4'hF;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`OFS_CONFIG, d);
      `CHK(d, `CFG_RESET);
      rd(`OFS_STATUS, d);
      `CHK(d[1:0], 2'h0);
      rd(8'h40, d);
      `CHK(resp, `RESP_SLVERR);
      // Halt on internal oscillator, then a status write that must not touch flags
      wr(`OFS_CONFIG, 32'h0000_0103);
      core_u.issue(4'h8);
      rd(`OFS_STATUS, d);
      `CHK(d[3:0], 4'h6);
      `CHK({hold, sys_en}, 2'h2);
      `CHK(osc_en, 1'b1);
      wr(`OFS_STATUS, 32'h0000_0000);
      `CHK(resp, `RESP_OKAY);
      rd(`OFS_STATUS, d);
      `CHK(d[1:0], 2'h2);
      rd(`OFS_CONFIG, d2);
      `CHK(d2, 32'h0000_0103);
      port_wake();
      rd(`OFS_STATUS, d);
      `CHK(d[5:0], 6'h12);
      // Disabled watchdog ignores the clear; enabled clear drops the power-down flag
      // Only byte lane 0 lands, so the upper bytes of the data are dropped
      wstrb <= 4'h1;
      wr(`OFS_CONFIG, 32'hFFFF_FF02);
      wstrb <= 4'hF;
      rd(`OFS_CONFIG, d);
      `CHK(d, 32'h0000_0102);
      core_u.issue(4'h1);
      rd(`OFS_STATUS, d);
      `CHK(d[1:0], 2'h2);
      wr(`OFS_CONFIG, 32'h0000_0103);
      core_u.issue(4'h1);
      rd(`OFS_STATUS, d);
      `CHK(d[1:0], 2'h0);
      // Paired mode on the instruction clock: one half alone must not clear
      wr(`OFS_CONFIG, 32'h0000_0111);
      repeat (400) @(posedge clk);
      core_u.issue(4'h2);
      rd(`OFS_COUNT, d);
      `CHK(d > 50, 1'b1);
      core_u.issue(4'h4);
      rd(`OFS_COUNT, d);
      `CHK(d < 8, 1'b1);
      // Instruction-clocked count stands still in halt
      wr(`OFS_CONFIG, 32'h0000_0101);
      core_u.issue(4'h8);
      rd(`OFS_COUNT, d);
      `CHK(osc_en, 1'b0);
      repeat (200) @(posedge clk);
      rd(`OFS_COUNT, d2);
      `CHK(d2, d);
      `CHK(d, 0);
      port_wake();
      // A request already pending at halt cannot wake
      irq_en <= 6'h01;
      irq_req <= 6'h01;
      core_u.issue(4'h8);
      // A falling edge on a port bit whose wake is not enabled must not wake either
      pa[1] <= 1'b0;
      repeat (1200) @(posedge clk);
      pa[1] <= 1'b1;
      rd(`OFS_STATUS, d);
      `CHK(d[3:2], 2'h1);
      port_wake();
      irq_req <= 6'h00;
      // Fresh request: enabled goes to interrupt entry; disabled or full stack resumes
      for (k = 0; k < 3; k++) begin
         irq_en <= (k == 1) ? 6'h00 : 6'h02;
         stack_full <= (k == 2);
         core_u.issue(4'h8);
         repeat (10) @(posedge clk);
         irq_req <= 6'h02;
         wait_ev(4'h3, n, hit);
         irq_req <= 6'h00;
         `CHK(hit, (k == 0) ? 4'h2 : 4'h1);
      end
      stack_full <= 1'b0;
      // Overflow while running, instruction clock, shortest ratio
      wr(`OFS_CONFIG, 32'h0000_0101);
      core_u.issue(4'h1);
      wait_ev(4'h4, n, hit);
      `CHK(n >= 32760 && n <= 32800, 1'b1);
      rd(`OFS_STATUS, d);
      `CHK(d[0], 1'b1);
      // Overflow in halt on the internal oscillator gives only a warm reset
      wr(`OFS_CONFIG, 32'h0000_0103);
      k = core_u.chip_cnt;
      core_u.issue(4'h8);
      wait_ev(4'h8, n, hit);
      `CHK(n >= 32700 && n <= 32900, 1'b1);
      `CHK(core_u.chip_cnt, k);
      rd(`OFS_STATUS, d);
      `CHK(d[1:0], 2'h3);
      // Reset pin low resets the chip and holds the count at zero
      pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(chip_rst, 1'b1);
      rd(`OFS_COUNT, d);
      `CHK(d, 0);
      pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      print_verdict();
   end

   // Hang guard, sized well above the two overflow waits
   initial begin
      #900000;
      mismatches++;
      print_verdict();
   end
endmodule
